// ===== src/adv_selftest_pkg.sv
package adv_selftest_pkg;

    localparam int ADDR_W = 14;
    localparam int DATA_W = 16;
    localparam int NUM_STREAMS = 32;

    // Register offsets
    localparam logic [13:0] ADV_BASE_OFS = 14'h00A3;
    localparam logic [13:0] ADV_LAST_OFS = 14'h00C2;
    localparam logic [13:0] SELF_TEST_OFS = 14'h014D;
    localparam logic [13:0] RATE_OFS = 14'h1001;
    localparam logic [13:0] IDENT_OFS = 14'h3FFF;

    // Field positions
    localparam int ENABLE_BIT = 12;
    localparam int RATE_LSB = 1;
    localparam int REV_LSB = 4;

    // One start/done/pass triple per memory, start bit positions
    localparam int BP_DATA_START_BIT = 11;
    localparam int LOC_DATA_START_BIT = 8;
    localparam int BP_CONN_START_BIT = 5;
    localparam int LOC_CONN_START_BIT = 2;

    // Reset values
    localparam logic [1:0] ADV_RESET = 2'h0;
    localparam logic [1:0] RATE_RESET = 2'h0;

    // Advance per code step in system clock cycles
    localparam int ADV_STEP_CYCLES = 2;

    typedef enum logic [1:0] {
        RATE_2M = 2'b00,
        RATE_4M = 2'b01,
        RATE_8M = 2'b10,
        RATE_16M = 2'b11
    } stream_rate_e;

    typedef enum logic [1:0] {
        MT_IDLE = 2'b00,
        MT_RUN = 2'b01,
        MT_DONE = 2'b10
    } mem_test_state_e;

    typedef struct packed {
        logic sel;
        logic wr;
        logic [13:0] addr;
        logic [15:0] wdata;
    } cpu_req_s;

    typedef struct packed {
        logic [3:0] start;
        logic [3:0] done;
        logic [3:0] pass;
    } mem_test_s;

endpackage : adv_selftest_pkg

// ===== src/switch_output_adv_selftest_regs.sv
`timescale 1ns/1ps
module switch_output_adv_selftest_regs
    import adv_selftest_pkg::*;
#(
    parameter int STREAMS = NUM_STREAMS,
    // Arbitrary neutral identification values
    parameter logic [3:0] SILICON_REVISION = 4'h5,
    parameter logic [2:0] PART_CODE = 3'h2
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire cpu_req_s cpu_req,
    output logic [15:0] cpu_rdata,
    output logic [2*STREAMS-1:0] backplane_adv_code,
    output logic [3*STREAMS-1:0] backplane_adv_cycles,
    output logic self_test_enable,
    output logic [3:0] mem_test_start_pulse,
    input wire logic [3:0] mem_test_finish,
    input wire logic [3:0] mem_test_result,
    output logic [1:0] stream_rate_code
);

    // The address window holds exactly this many advancement registers
    if (STREAMS != NUM_STREAMS) begin : g_bad_streams
        $error("STREAMS must match the register block span");
    end

    logic [1:0] adv_r [STREAMS];
    logic enable_r;
    logic [3:0] start_r;
    logic [3:0] done_r;
    logic [3:0] pass_r;
    logic [1:0] rate_r;
    logic [3:0] start_launch;
    logic [15:0] self_test_word;
    logic [15:0] rdata_nxt;
    logic [15:0] rdata_r;
    logic adv_hit;
    logic [13:0] adv_index;
    logic wr_en;

    assign wr_en = cpu_req.sel && cpu_req.wr;
    assign adv_index = cpu_req.addr - ADV_BASE_OFS;
    assign adv_hit = (cpu_req.addr >= ADV_BASE_OFS)
        && (cpu_req.addr <= ADV_LAST_OFS);

    // Advancement registers, reserved bits dropped
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < STREAMS; i++) begin
                adv_r[i] <= ADV_RESET;
            end
        end else if (wr_en && adv_hit) begin
            adv_r[adv_index[4:0]] <= cpu_req.wdata[1:0];
        end
    end

    // Code to advance count per stream; zero keeps frame alignment
    always_comb begin
        for (int i = 0; i < STREAMS; i++) begin
            backplane_adv_code[2*i +: 2] = adv_r[i];
            backplane_adv_cycles[3*i +: 3] =
                3'(adv_r[i]) * 3'(ADV_STEP_CYCLES);
        end
    end

    // Enable bit; start edges only count if enable was already high
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            enable_r <= 1'b0;
        end else if (wr_en && cpu_req.addr == SELF_TEST_OFS) begin
            enable_r <= cpu_req.wdata[ENABLE_BIT];
        end
    end

    always_comb begin
        mem_test_s w;
        w = '0;
        w.start = {cpu_req.wdata[BP_DATA_START_BIT],
                   cpu_req.wdata[LOC_DATA_START_BIT],
                   cpu_req.wdata[BP_CONN_START_BIT],
                   cpu_req.wdata[LOC_CONN_START_BIT]};
        start_launch = '0;
        if (wr_en && cpu_req.addr == SELF_TEST_OFS && enable_r
            && cpu_req.wdata[ENABLE_BIT]) begin
            start_launch = w.start & ~start_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            start_r <= 4'h0;
        end else if (wr_en && cpu_req.addr == SELF_TEST_OFS) begin
            start_r <= {cpu_req.wdata[BP_DATA_START_BIT],
                        cpu_req.wdata[LOC_DATA_START_BIT],
                        cpu_req.wdata[BP_CONN_START_BIT],
                        cpu_req.wdata[LOC_CONN_START_BIT]};
        end
    end

    assign mem_test_start_pulse = start_launch;
    assign self_test_enable = enable_r;

    // Done and pass set from the engines; a start pulse or a low enable clears them, but an engine finish in the same cycle wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            done_r <= 4'h0;
            pass_r <= 4'h0;
        end else begin
            for (int m = 0; m < 4; m++) begin
                if (mem_test_finish[m]) begin
                    done_r[m] <= 1'b1;
                    pass_r[m] <= mem_test_result[m];
                end else if (start_launch[m] || !enable_r) begin
                    done_r[m] <= 1'b0;
                    pass_r[m] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rate_r <= RATE_RESET;
        end else if (wr_en && cpu_req.addr == RATE_OFS) begin
            rate_r <= cpu_req.wdata[RATE_LSB +: 2];
        end
    end

    assign stream_rate_code = rate_r;

    always_comb begin
        self_test_word = '0;
        self_test_word[ENABLE_BIT] = enable_r;
        self_test_word[11:9] = {start_r[3], done_r[3], pass_r[3]};
        self_test_word[8:6] = {start_r[2], done_r[2], pass_r[2]};
        self_test_word[5:3] = {start_r[1], done_r[1], pass_r[1]};
        self_test_word[2:0] = {start_r[0], done_r[0], pass_r[0]};
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_nxt = '0;
        if (adv_hit) begin
            rdata_nxt[1:0] = adv_r[adv_index[4:0]];
        end else if (cpu_req.addr == SELF_TEST_OFS) begin
            rdata_nxt = self_test_word;
        end else if (cpu_req.addr == RATE_OFS) begin
            rdata_nxt[RATE_LSB +: 2] = rate_r;
        end else if (cpu_req.addr == IDENT_OFS) begin
            rdata_nxt[REV_LSB +: 4] = SILICON_REVISION;
            rdata_nxt[2:0] = PART_CODE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_r <= 16'h0000;
        end else if (cpu_req.sel && !cpu_req.wr) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign cpu_rdata = rdata_r;

endmodule : switch_output_adv_selftest_regs

// ===== test/adv_selftest_asserts.sv
`timescale 1ns/1ps
module adv_selftest_asserts
    import adv_selftest_pkg::*;
#(
    parameter int STREAMS = NUM_STREAMS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire cpu_req_s cpu_req,
    input wire logic [15:0] cpu_rdata,
    input wire logic [2*STREAMS-1:0] backplane_adv_code,
    input wire logic [3*STREAMS-1:0] backplane_adv_cycles,
    input wire logic self_test_enable,
    input wire logic [3:0] mem_test_start_pulse,
    input wire logic [3:0] mem_test_finish,
    input wire logic [3:0] mem_test_result,
    input wire logic [1:0] stream_rate_code
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic wr_st, wr_rt, rd_id;
    assign wr_st = cpu_req.sel && cpu_req.wr && cpu_req.addr == SELF_TEST_OFS;
    assign wr_rt = cpu_req.sel && cpu_req.wr && cpu_req.addr == RATE_OFS;
    assign rd_id = cpu_req.sel && !cpu_req.wr && cpu_req.addr == IDENT_OFS;
    AST_RESET_VAL: assert property (disable iff (1'b0) sys_rst |=>
        cpu_rdata == 16'h0000 && stream_rate_code == 2'h0 && !self_test_enable)
        else $error("reset value wrong");
    AST_ID_RSVD: assert property (rd_id |=>
        cpu_rdata[15:8] == 8'h00 && !cpu_rdata[3])
        else $error("id reserved bits set");
    AST_START_EN: assert property (mem_test_start_pulse != 4'h0 |->
        self_test_enable && wr_st && cpu_req.wdata[ENABLE_BIT])
        else $error("start without enable");
    AST_START_BP: assert property (mem_test_start_pulse[3] |->
        cpu_req.wdata[BP_DATA_START_BIT] ##1 !mem_test_start_pulse[3])
        else $error("bp data start wrong");
    AST_START_LC: assert property (mem_test_start_pulse[0] |->
        cpu_req.wdata[LOC_CONN_START_BIT] ##1 !mem_test_start_pulse[0])
        else $error("loc conn start wrong");
    AST_EN_WR: assert property (wr_st |=>
        self_test_enable == $past(cpu_req.wdata[ENABLE_BIT]))
        else $error("enable not written");
    AST_RATE_WR: assert property (wr_rt |=>
        stream_rate_code == $past(cpu_req.wdata[2:1]))
        else $error("rate not written");
    AST_ADV_CYC: assert property (
        backplane_adv_cycles[2:0] == {backplane_adv_code[1:0], 1'b0} &&
        backplane_adv_cycles[3*STREAMS-1 -: 3] ==
        {backplane_adv_code[2*STREAMS-1 -: 2], 1'b0})
        else $error("advance cycles wrong");
endmodule : adv_selftest_asserts

bind switch_output_adv_selftest_regs adv_selftest_asserts #(.STREAMS(STREAMS))
    adv_selftest_asserts_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .backplane_adv_code(backplane_adv_code),
    .backplane_adv_cycles(backplane_adv_cycles),
    .self_test_enable(self_test_enable),
    .mem_test_start_pulse(mem_test_start_pulse),
    .mem_test_finish(mem_test_finish), .mem_test_result(mem_test_result),
    .stream_rate_code(stream_rate_code));

// ===== test/switch_output_adv_selftest_regs_tb.sv
`timescale 1ns/1ps
module switch_output_adv_selftest_regs_tb
    import adv_selftest_pkg::*;
;
    logic ref_clk, sys_rst, test_en;
    cpu_req_s cpu_req;
    logic [15:0] cpu_rdata;
    logic [63:0] adv_code;
    logic [95:0] adv_cyc;
    logic [3:0] pulse, finish, result, pulse_log;
    logic [1:0] rate;
    int err_total = 0;
    int num_checks = 0;
    // Arbitrary identification values
    switch_output_adv_selftest_regs #(.SILICON_REVISION(4'hA),
        .PART_CODE(3'h3)) switch_output_adv_selftest_regs_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .cpu_req(cpu_req),
        .cpu_rdata(cpu_rdata), .backplane_adv_code(adv_code),
        .backplane_adv_cycles(adv_cyc), .self_test_enable(test_en),
        .mem_test_start_pulse(pulse), .mem_test_finish(finish),
        .mem_test_result(result), .stream_rate_code(rate));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) pulse_log <= pulse_log | pulse;
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string n, input logic [15:0] e, s);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [13:0] a, logic [15:0] d);
        @(posedge ref_clk);
        #1 cpu_req = '{1'b1, w, a, d};
        @(posedge ref_clk);
        #1 cpu_req.sel = 1'b0;
    endtask : acc
    task automatic rd(input logic [13:0] a, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        chk("rdata", e, cpu_rdata);
    endtask : rd
    initial begin
        #20000 err_total++;
        stop_test();
    end
    initial begin
        cpu_req = '0;
        finish = 4'h0;
        result = 4'h0;
        pulse_log = 4'h0;
        sys_rst = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        rd(ADV_LAST_OFS, 16'h0000);
        rd(SELF_TEST_OFS, 16'h0000);
        rd(RATE_OFS, 16'h0000);
        rd(IDENT_OFS, 16'h00A3);
        acc(1'b1, IDENT_OFS, 16'h00F7);
        rd(IDENT_OFS, 16'h00A3);
        for (int n = 0; n < 32; n++) begin
            acc(1'b1, ADV_BASE_OFS + 14'(n), 16'(n % 4));
        end
        for (int n = 0; n < 32; n++) begin
            rd(ADV_BASE_OFS + 14'(n), 16'(n % 4));
            chk("code", 16'(n % 4), 16'(adv_code[2*n +: 2]));
            chk("adv", 16'(2 * (n % 4)), 16'(adv_cyc[3*n +: 3]));
        end
        rd(ADV_LAST_OFS + 14'h1, 16'h0000);
        rd(ADV_BASE_OFS - 14'h1, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, RATE_OFS, 16'(2 * c));
            chk("rate", 16'(c), {14'h0, rate});
        end
        rd(RATE_OFS, 16'h0006);
        acc(1'b1, SELF_TEST_OFS, 16'h0800);
        chk("pulse", 16'h0000, {12'h0, pulse_log});
        acc(1'b1, SELF_TEST_OFS, 16'h1000);
        chk("enable", 16'h0001, {15'h0, test_en});
        acc(1'b1, SELF_TEST_OFS, 16'h1924);
        chk("pulse", 16'h000F, {12'h0, pulse_log});
        pulse_log = 4'h0;
        acc(1'b1, SELF_TEST_OFS, 16'h1924);
        chk("pulse", 16'h0000, {12'h0, pulse_log});
        finish = 4'hF;
        result = 4'hA;
        @(posedge ref_clk);
        #1 finish = 4'h0;
        rd(SELF_TEST_OFS, 16'h1FBE);
        acc(1'b1, SELF_TEST_OFS, 16'h1FFF);
        rd(SELF_TEST_OFS, 16'h1FBE);
        acc(1'b1, SELF_TEST_OFS, 16'h0000);
        chk("enable", 16'h0000, {15'h0, test_en});
        stop_test();
    end
endmodule : switch_output_adv_selftest_regs_tb
